/* File: shared/tsv_beat_if.sv */
// Purpose: carries transmit beats to the header parser and flags back
// Assumes: one clock shared by both ends
// Notes: flags come from the parser's flip-flops
`timescale 1ns/100ps
interface tsv_beat_if;
    logic beat;
    logic sof;
    logic [63:0] data;
    logic [7:0] lane_en;
    logic vlan_en;
    logic mcast;
    logic bcast;
    logic vlan;
    logic ctl;
    modport core (output beat, sof, data, lane_en, vlan_en,
                  input mcast, bcast, vlan, ctl);
    modport parser (input beat, sof, data, lane_en, vlan_en,
                    output mcast, bcast, vlan, ctl);
endinterface : tsv_beat_if

/* File: shared/tsv_consts.svh */
// Purpose: offsets, field positions and reset values of the tx stats block
// Assumes: included by the package, the bench and the assertion module
// Notes: definitions only
`ifndef TSV_CONSTS_SVH
`define TSV_CONSTS_SVH
// register word indices on the ahb-lite slave, byte address is four times
`define TSV_OFS_CTRL 6'h00
`define TSV_OFS_STAT 6'h01
`define TSV_OFS_MASK 6'h02
`define TSV_OFS_LAST 6'h03
`define TSV_OFS_FCNT 6'h04
// control register fields and reset value
`define TSV_CTRL_VLAN 0
`define TSV_CTRL_RST 1'b0
// event bits, shared by status and mask
`define TSV_EV_DONE 0
`define TSV_EV_UNDR 1
`define TSV_EV_SAT 2
`define TSV_EV_W 3
// transmit and receive vector widths without priority flow control
`define TSV_TX_W 26
`define TSV_RX_W 30
// transmit vector field positions
`define TSV_B_PFC 26
`define TSV_B_PAUSE 25
`define TSV_B_BV_HI 24
`define TSV_B_BV_LO 21
`define TSV_B_VLAN 20
`define TSV_B_LEN_HI 19
`define TSV_B_LEN_LO 5
`define TSV_B_CTL 4
`define TSV_B_UNDR 3
`define TSV_B_MCAST 2
`define TSV_B_BCAST 1
`define TSV_B_GOOD 0
// frame constants
`define TSV_LEN_MAX 15'h7fff
`define TSV_TYPE_CTL 16'h8808
`define TSV_TYPE_VLAN 16'h8100
`endif

/* File: shared/tsv_pkg.sv */
// Purpose: state types of the tx stats block
// Assumes: tsv_consts.svh holds the event and vector widths
// Notes: each module keeps all its state in one of these structs
`include "tsv_consts.svh"
package tsv_pkg;
    // parser state: beats since start, header flags
    typedef struct packed {
        logic [1:0] beat;
        logic mcast;
        logic bcast;
        logic vlan;
        logic ctl;
    } tsv_parse_t;

    // core state: bus slave, events, frame totals, outputs
    typedef struct packed {
        logic dp_act;
        logic dp_wr;
        logic [5:0] dp_idx;
        logic dp_hit;
        logic rd_done;
        logic [31:0] rdata;
        logic vlan_en;
        logic [`TSV_EV_W-1:0] ev_stat;
        logic [`TSV_EV_W-1:0] ev_mask;
        logic irq;
        logic [14:0] len;
        logic undr;
        logic err;
        logic pause;
        logic pfc;
        logic pend;
        logic [14:0] len_fin;
        logic undr_fin;
        logic good_fin;
        logic pause_fin;
        logic pfc_fin;
        logic sat_fin;
        logic [`TSV_TX_W:0] vec;
        logic vld;
        logic [3:0] bv;
        logic [`TSV_RX_W:0] rxvec;
        logic rxvld;
        logic [31:0] fcnt;
    } tsv_core_t;
endpackage : tsv_pkg

/* File: sim/tb.sv */
// Purpose: self-checking bench of the tx statistics block
// Assumes: ahb-lite master, one wait state on reads
// Notes: random frames from a fixed seed plus corner cases
`timescale 1ns/100ps
`include "tsv_consts.svh"
module tb;
    import tsv_pkg::*;
    localparam int TX_W = `TSV_TX_W + 1;
    localparam int RX_W = `TSV_RX_W + 1;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] haddr = '0, hwdata = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0, rxv = 1'b0;
    logic beat = 0, sof = 0, eof = 0, und = 0, err = 0, pse = 0, pfc = 0;
    logic [63:0] data = '0;
    logic [7:0] lanes = '0;
    logic [RX_W-1:0] rxf = '0;
    logic [31:0] hrdata, m_fr, m_good, m_bytes, last_e;
    logic [31:0] q[$];
    logic hrdy, hresp, irq, txv, rxvo;
    logic [TX_W-1:0] txvec;
    logic [RX_W-1:0] rxvec;
    int n_fail = 0, samples_checked = 0, tot = 0, ngood = 0, nfr = 0;
    logic [15:0] tyt[3] = '{16'h0800, 16'h8808, 16'h8100};

    // 40 MHz clock
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    tsv_tx_stats #(.PFC_EN(1'b1)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .irq_o(irq), .txp_beat_i(beat), .txp_sof_i(sof), .txp_eof_i(eof),
        .txp_data_i(data), .txp_lane_en_i(lanes), .txp_underrun_i(und),
        .txp_error_i(err), .txp_pause_i(pse), .txp_pfc_i(pfc),
        .rx_flags_i(rxf), .rx_flags_valid_i(rxv),
        .tx_statistics_vector_o(txvec), .tx_statistics_valid_o(txv),
        .rx_statistics_vector_o(rxvec), .rx_statistics_valid_o(rxvo));

    tsv_client_mdl #(.TX_W(TX_W)) u_cli (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .vec_i(txvec), .vld_i(txv), .frames_o(m_fr),
        .good_o(m_good), .bytes_o(m_bytes));

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // wait for hready at a rising edge, bounded
    task automatic wt;
        int i;
        i = 0;
        do begin
            @(posedge clk_sys_i);
            i++;
        end while (hrdy !== 1'b1 && i < 20);
        if (hrdy !== 1'b1) begin
            n_fail++;
            results();
        end
    endtask : wt

    task automatic ahb(input logic [31:0] a, d, input logic w,
                       output logic [31:0] r);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic wrr(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(a, d, 1'b1, r);
    endtask : wrr

    task automatic rdc(input string nm, input logic [31:0] a, e);
        logic [31:0] r;
        ahb(a, 32'h0, 1'b0, r);
        chk(nm, r, e);
    endtask : rdc

    // frame byte: address kind, type field, then counting pattern
    function automatic logic [7:0] fb(int i, int k, logic [15:0] t);
        if (i < 6)
            return (k == 2) ? 8'hff : (i == 0 ? {7'h1, k[0]} : 8'h00);
        if (i == 12)
            return t[15:8];
        if (i == 13)
            return t[7:0];
        return i[7:0];
    endfunction : fb

    function automatic logic [31:0] ev(int n, int k, logic [15:0] t,
                                       logic [3:0] f, logic ve);
        logic [31:0] v;
        v = '0;
        v[26] = f[3];
        v[25] = f[2];
        v[20] = n >= 14 && ve && t == 16'h8100;
        v[19:5] = n > 32767 ? 15'h7fff : n[14:0];
        v[4] = n >= 14 && t == 16'h8808;
        v[3] = f[0];
        v[2] = k != 0;
        v[1] = k == 2;
        v[0] = f[1:0] == 2'b00;
        return v;
    endfunction : ev

    // f: pfc, pause, error, underrun
    task automatic send(input int n, k, input logic [15:0] t,
                        input logic [3:0] f, input logic ve);
        int m;
        for (int o = 0; o < n; o += 8) begin
            m = (n - o < 8) ? n - o : 8;
            beat <= 1'b1;
            sof <= (o == 0);
            eof <= (o + 8 >= n);
            lanes <= 8'((16'h1 << m) - 1);
            for (int j = 0; j < 8; j++)
                data[8*j +: 8] <= fb(o + j, k, t);
            und <= f[0] && (o + 8 >= n);
            err <= f[1] && o == 0;
            pse <= f[2] && o == 0;
            pfc <= f[3] && (o + 8 >= n);
            @(posedge clk_sys_i);
        end
        last_e = ev(n, k, t, f, ve);
        q.push_back(last_e);
        tot += n;
        nfr++;
        ngood += (f[1:0] == 2'b00);
    endtask : send

    task automatic idle(input int c);
        {beat, sof, eof, und, err, pse, pfc} <= '0;
        repeat (c) @(posedge clk_sys_i);
    endtask : idle

    // compare each report with the oldest frame sent
    always @(posedge clk_sys_i) begin
        if (!rst_i && txv === 1'b1) begin
            if (q.size() == 0)
                chk("spurious", 32'h1, 32'h0);
            else
                chk("txvec", 32'(txvec) & ~32'h01e0_0000,
                    q.pop_front());
        end
    end

    initial begin
        logic [31:0] r;
        void'($urandom(7775));
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int a = 0; a < 6; a++)
            rdc("reg", 32'(a * 4), 32'h0);
        wrr(32'h8, 32'h5);
        wrr(32'h108, 32'h0);
        rdc("mask", 32'h8, 32'h5);
        rdc("hi", 32'h108, 32'h0);
        for (int i = 0; i < 40; i++) begin
            if (i == 20) begin
                idle(2);
                wrr(32'h0, 32'h1);
            end
            send(60 + $urandom % 1500, $urandom % 3, tyt[$urandom % 3],
                 4'($urandom), i >= 20);
            if ($urandom % 2)
                idle(1 + $urandom % 4);
        end
        send(1, 0, 16'h0, 4'h1, 1'b1);
        send(32800, 1, 16'h8100, 4'h0, 1'b1);
        idle(6);
        $display("test frames done");
        chk("queue", q.size(), 32'h0);
        chk("bytes", m_bytes, tot);
        chk("frames", m_fr, nfr);
        chk("good", m_good, ngood);
        rdc("last", 32'hc, last_e);
        rdc("fcnt", 32'h10, nfr);
        rdc("stat", 32'h4, 32'h7);
        chk("irq", {31'h0, irq}, 32'h1);
        wrr(32'h4, 32'h7);
        repeat (3) @(posedge clk_sys_i);
        chk("irq", {31'h0, irq}, 32'h0);
        wrr(32'h8, 32'h0);
        send(64, 2, 16'h0800, 4'h0, 1'b1);
        idle(6);
        chk("irq", {31'h0, irq}, 32'h0);
        rdc("stat", 32'h4, 32'h1);
        $display("test irq done");
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            rxf <= r[RX_W-1:0];
            rxv <= 1'b1;
            @(posedge clk_sys_i);
            rxv <= 1'b0;
            @(posedge clk_sys_i);
            chk("rxv", {31'h0, rxvo}, 32'h1);
            chk("rxvec", 32'(rxvec), 32'(r[RX_W-1:0]));
        end
        $display("test rx done");
        results();
    end
endmodule : tb

/* File: sim/tsv_client_mdl.sv */
// Purpose: client that counts per-frame transmit statistics
// Assumes: same clock as the mac
// Notes: flags read only under valid, byte count every cycle
`timescale 1ns/100ps
module tsv_client_mdl #(
    parameter int TX_W = 27
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // statistics from the mac
    input wire logic [TX_W-1:0] vec_i,
    input wire logic vld_i,
    // running totals
    output logic [31:0] frames_o,
    output logic [31:0] good_o,
    output logic [31:0] bytes_o
);
    // totals; flags ignored unless valid
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            frames_o <= '0;
            good_o <= '0;
            bytes_o <= '0;
        end else begin
            bytes_o <= bytes_o + 32'(vec_i[24:21]);
            if (vld_i) begin
                frames_o <= frames_o + 32'h1;
                good_o <= good_o + 32'(vec_i[0]);
            end
        end
    end
endmodule : tsv_client_mdl

/* File: sim/tsv_tx_stats_sva.sv */
// Purpose: timing checks on the tx and rx statistics outputs
// Assumes: one clock, asynchronous active high reset
// Notes: bound into tsv_tx_stats
`timescale 1ns/100ps
`include "tsv_consts.svh"
module tsv_tx_stats_sva #(
    parameter bit PFC_EN = 1'b0,
    localparam int TX_W = `TSV_TX_W + int'(PFC_EN),
    localparam int RX_W = `TSV_RX_W + int'(PFC_EN)
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // beats and receive flags in
    input wire logic txp_beat_i,
    input wire logic txp_eof_i,
    input wire logic [7:0] txp_lane_en_i,
    input wire logic txp_underrun_i,
    input wire logic [RX_W-1:0] rx_flags_i,
    input wire logic rx_flags_valid_i,
    // statistics out
    input wire logic [TX_W-1:0] tx_statistics_vector_o,
    input wire logic tx_statistics_valid_o,
    input wire logic [RX_W-1:0] rx_statistics_vector_o,
    input wire logic rx_statistics_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // frame end and its report two edges later
    sequence s_end;
        txp_beat_i && txp_eof_i;
    endsequence
    sequence s_rep;
        ##2 tx_statistics_valid_o;
    endsequence
    property p_vld_lat;
        s_end |-> s_rep;
    endproperty
    a_vld_lat: assert property (p_vld_lat)
        else $error("no report two cycles after frame end");
    property p_vld_cause;
        tx_statistics_valid_o |-> $past(txp_beat_i && txp_eof_i, 2);
    endproperty
    a_vld_cause: assert property (p_vld_cause)
        else $error("report without a finished frame");
    property p_undr;
        txp_beat_i && txp_eof_i && txp_underrun_i |-> ##2
            (tx_statistics_valid_o && tx_statistics_vector_o[3]
             && !tx_statistics_vector_o[0]);
    endproperty
    a_undr: assert property (p_undr)
        else $error("underrun frame not flagged");
    property p_bv;
        tx_statistics_vector_o[24:21] == ($past(txp_beat_i) ?
            4'($countones($past(txp_lane_en_i))) : 4'h0);
    endproperty
    a_bv: assert property (p_bv)
        else $error("byte count not from previous cycle");
    property p_bv_max;
        tx_statistics_vector_o[24:21] <= 4'h8;
    endproperty
    a_bv_max: assert property (p_bv_max)
        else $error("byte count above eight");
    property p_hold;
        !tx_statistics_valid_o |-> $stable(tx_statistics_vector_o[20:0])
            && $stable(tx_statistics_vector_o[TX_W-1:25]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("frame flags moved outside a report");
    property p_rx_vld;
        rx_flags_valid_i |=> rx_statistics_valid_o;
    endproperty
    a_rx_vld: assert property (p_rx_vld)
        else $error("receive strobe missing");
    property p_rx_vec;
        rx_flags_valid_i |=> rx_statistics_vector_o == $past(rx_flags_i);
    endproperty
    a_rx_vec: assert property (p_rx_vec)
        else $error("receive vector wrong");
endmodule : tsv_tx_stats_sva
bind tsv_tx_stats tsv_tx_stats_sva #(.PFC_EN(PFC_EN)) u_sva (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .txp_beat_i(txp_beat_i),
    .txp_eof_i(txp_eof_i),
    .txp_lane_en_i(txp_lane_en_i),
    .txp_underrun_i(txp_underrun_i),
    .rx_flags_i(rx_flags_i),
    .rx_flags_valid_i(rx_flags_valid_i),
    .tx_statistics_vector_o(tx_statistics_vector_o),
    .tx_statistics_valid_o(tx_statistics_valid_o),
    .rx_statistics_vector_o(rx_statistics_vector_o),
    .rx_statistics_valid_o(rx_statistics_valid_o)
);

/* File: src/tsv_parser.sv */
// Purpose: extracts address and type flags from the head of each frame
// Assumes: lane 0 carries the first byte on the wire, full beats until end
// Notes: flags hold until the next start of frame
`timescale 1ns/100ps
module tsv_parser
    import tsv_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // beats in, flags out
    tsv_beat_if.parser bi
);
    tsv_parse_t s_q;
    tsv_parse_t s_d;
    logic [15:0] ty12;
    logic [15:0] ty16;

    // length/type words at bytes 12-13 and 16-17, first byte is msb
    assign ty12 = {bi.data[39:32], bi.data[47:40]};
    assign ty16 = {bi.data[7:0], bi.data[15:8]};

    // next state of the header walk
    always_comb begin
        s_d = s_q;
        if (bi.beat && bi.sof) begin
            s_d = '0;
            s_d.mcast = bi.lane_en[0] & bi.data[0]; // R14
            s_d.bcast = (&bi.lane_en[5:0]) & (&bi.data[47:0]); // R15
        end else if (bi.beat) begin
            if (s_q.beat != 2'h3) begin
                s_d.beat = s_q.beat + 2'h1;
            end
            if (s_q.beat == 2'h0 && bi.lane_en[5]) begin
                s_d.vlan = bi.vlan_en && ty12 == `TSV_TYPE_VLAN; // R9
                s_d.ctl = ty12 == `TSV_TYPE_CTL; // R12
            end
            // a tagged frame carries its real type four bytes later
            if (s_q.beat == 2'h1 && s_q.vlan && bi.lane_en[1]) begin
                s_d.ctl = ty16 == `TSV_TYPE_CTL; // R12
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bi.mcast = s_q.mcast;
    assign bi.bcast = s_q.bcast;
    assign bi.vlan = s_q.vlan;
    assign bi.ctl = s_q.ctl;
endmodule : tsv_parser

/* File: src/tsv_tx_stats.sv */
// Purpose: per-frame transmit statistics vector with ahb-lite registers
// Assumes: beat inputs come from the tx pipeline on clk_sys_i, phy side
// Notes: one valid pulse per frame, two cycles after its last beat
//
// Notes on behaviour
// R1: transmit vector is 26 bits, 27 bits when priority flow control exists.
// R2: receive vector is 30 bits, 31 with flow control, with own strobe.
// R3: per-frame transmit flags are driven only after the frame has finished.
// R4: fields other than byte count mean something only while valid is high.
// R5: bits 24:21 give bytes sent last cycle, from 0 to 8.
// R6: byte count updates every cycle, from a different stage than flags.
// R7: bit 26 marks a flow control frame the block generated itself.
// R8: bit 25 marks a pause frame started by the client's pause request.
// R9: bit 20 marks a vlan tagged frame while vlan handling is enabled.
// R10: bits 19:5 give frame length, saturating at 32767.
// R11: length counts bytes seen at the phy, padding and fcs included.
// R12: bit 4 marks a frame whose length/type field held 88-08.
// R13: bit 3 marks a frame cut short by a client underrun.
// R14: bit 2 marks a multicast destination address.
// R15: bit 1 marks the broadcast destination address.
// R16: bit 0 marks a frame sent completely without error.
// R17: valid pulses one cycle per frame with flags stable in that cycle.
`timescale 1ns/100ps
module tsv_tx_stats
    import tsv_pkg::*;
#(
    parameter bit PFC_EN = 1'b0,
    localparam int TX_W = `TSV_TX_W + int'(PFC_EN),
    localparam int RX_W = `TSV_RX_W + int'(PFC_EN)
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // interrupt
    output logic irq_o,
    // transmit pipeline beats, phy side
    input wire logic txp_beat_i,
    input wire logic txp_sof_i,
    input wire logic txp_eof_i,
    input wire logic [63:0] txp_data_i,
    input wire logic [7:0] txp_lane_en_i,
    input wire logic txp_underrun_i,
    input wire logic txp_error_i,
    input wire logic txp_pause_i,
    input wire logic txp_pfc_i,
    // receive flags from the receive path
    input wire logic [RX_W-1:0] rx_flags_i,
    input wire logic rx_flags_valid_i,
    // statistics outputs
    output logic [TX_W-1:0] tx_statistics_vector_o,
    output logic tx_statistics_valid_o,
    output logic [RX_W-1:0] rx_statistics_vector_o,
    output logic rx_statistics_valid_o
);
    tsv_core_t s_q;
    tsv_core_t s_d;
    tsv_beat_if u_bi();

    logic bus_take;
    logic [3:0] beat_cnt;
    logic [3:0] lanes_now;
    logic [14:0] len_base;
    logic [14:0] len_new;
    logic len_sat;
    logic undr_all;
    logic err_all;
    logic [`TSV_EV_W-1:0] ev_set;
    logic [`TSV_EV_W-1:0] ev_clr;

    // number of enabled lanes in a beat
    function automatic logic [3:0] lane_cnt(input logic [7:0] en);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, en[i]};
        end
        return c;
    endfunction : lane_cnt

    // length add that sticks at the top of the 15-bit field
    function automatic logic [15:0] len_add(input logic [14:0] a,
                                            input logic [3:0] b);
        logic [15:0] t;
        t = {1'b0, a} + {12'h000, b};
        if (t[15] || t[14:0] == `TSV_LEN_MAX) begin
            return {1'b1, `TSV_LEN_MAX};
        end
        return {1'b0, t[14:0]};
    endfunction : len_add

    // header parser sees the same beats
    tsv_parser u_parser (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .bi(u_bi.parser)
    );

    // beats and the vlan switch toward the parser
    assign u_bi.beat = txp_beat_i;
    assign u_bi.sof = txp_sof_i;
    assign u_bi.data = txp_data_i;
    assign u_bi.lane_en = txp_lane_en_i;
    assign u_bi.vlan_en = s_q.vlan_en;

    // address phase taken when selected, non-idle and bus ready
    assign bus_take = hsel_i && htrans_i[1] && hready_i;

    // per-beat quantities of the current frame
    assign lanes_now = lane_cnt(txp_lane_en_i);
    assign beat_cnt = txp_beat_i ? lanes_now : 4'h0;
    // a start beat drops the totals of an earlier frame
    assign len_base = txp_sof_i ? 15'h0000 : s_q.len;
    assign {len_sat, len_new} = len_add(len_base, beat_cnt); // R10 R11
    assign undr_all = (txp_sof_i ? 1'b0 : s_q.undr) | txp_underrun_i;
    assign err_all = (txp_sof_i ? 1'b0 : s_q.err) | txp_error_i;

    // events raised while the frame report goes out
    always_comb begin
        ev_set = '0;
        ev_set[`TSV_EV_DONE] = s_q.pend;
        ev_set[`TSV_EV_UNDR] = s_q.pend && s_q.undr_fin;
        ev_set[`TSV_EV_SAT] = s_q.pend && s_q.sat_fin;
    end

    // write-one-to-clear of the status register
    always_comb begin
        ev_clr = '0;
        if (s_q.dp_act && s_q.dp_wr && s_q.dp_hit &&
            s_q.dp_idx == `TSV_OFS_STAT) begin
            ev_clr = hwdata_i[`TSV_EV_W-1:0];
        end
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;

        // bus: data phase ends on ready, a new address phase may open
        if (bus_take) begin
            s_d.dp_act = 1'b1;
            s_d.dp_wr = hwrite_i;
            s_d.dp_idx = haddr_i[7:2];
            s_d.dp_hit = haddr_i[31:8] == 24'h000000;
            s_d.rd_done = 1'b0;
        end else if (hready_i) begin
            s_d.dp_act = 1'b0;
        end

        // register writes in the data phase, unmapped ones are dropped
        if (s_q.dp_act && s_q.dp_wr && s_q.dp_hit) begin
            case (s_q.dp_idx)
                `TSV_OFS_CTRL: begin
                    s_d.vlan_en = hwdata_i[`TSV_CTRL_VLAN];
                end
                `TSV_OFS_MASK: begin
                    s_d.ev_mask = hwdata_i[`TSV_EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // reads take one wait cycle to load the data flops
        if (s_q.dp_act && !s_q.dp_wr && !s_q.rd_done) begin
            s_d.rd_done = 1'b1;
            s_d.rdata = 32'h0000_0000;
            if (s_q.dp_hit) begin
                case (s_q.dp_idx)
                    `TSV_OFS_CTRL: begin
                        s_d.rdata[`TSV_CTRL_VLAN] = s_q.vlan_en;
                    end
                    `TSV_OFS_STAT: begin
                        s_d.rdata[`TSV_EV_W-1:0] = s_q.ev_stat;
                    end
                    `TSV_OFS_MASK: begin
                        s_d.rdata[`TSV_EV_W-1:0] = s_q.ev_mask;
                    end
                    `TSV_OFS_LAST: begin
                        s_d.rdata[`TSV_TX_W:0] = s_q.vec;
                    end
                    `TSV_OFS_FCNT: begin
                        s_d.rdata = s_q.fcnt;
                    end
                    default: begin
                        s_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // sticky events: a set in the clearing cycle survives
        s_d.ev_stat = (s_q.ev_stat & ~ev_clr) | ev_set;
        s_d.irq = |(s_d.ev_stat & s_d.ev_mask);

        // byte count of the beat just past, every cycle
        s_d.bv = beat_cnt; // R5 R6

        // accumulate the frame while its beats pass
        if (txp_beat_i) begin
            s_d.len = len_new; // R10 R11
            s_d.undr = undr_all; // R13
            s_d.err = err_all;
            s_d.pause = (txp_sof_i ? 1'b0 : s_q.pause) | txp_pause_i;
            s_d.pfc = PFC_EN & ((txp_sof_i ? 1'b0 : s_q.pfc) | txp_pfc_i);
        end

        // last beat: freeze the totals for the report
        s_d.pend = 1'b0;
        if (txp_beat_i && txp_eof_i) begin
            s_d.pend = 1'b1; // R3
            s_d.len_fin = len_new;
            s_d.sat_fin = len_sat;
            s_d.undr_fin = undr_all;
            s_d.good_fin = !undr_all && !err_all; // R16
            s_d.pause_fin = s_d.pause;
            s_d.pfc_fin = s_d.pfc;
        end

        // report cycle: flags loaded once, then held
        s_d.vld = 1'b0;
        if (s_q.pend) begin
            s_d.vld = 1'b1; // R17
            s_d.fcnt = s_q.fcnt + 32'h0000_0001;
            s_d.vec = '0;
            s_d.vec[`TSV_B_PFC] = PFC_EN & s_q.pfc_fin; // R7
            s_d.vec[`TSV_B_PAUSE] = s_q.pause_fin; // R8
            s_d.vec[`TSV_B_VLAN] = u_bi.vlan; // R9
            s_d.vec[`TSV_B_LEN_HI:`TSV_B_LEN_LO] = s_q.len_fin; // R10
            s_d.vec[`TSV_B_CTL] = u_bi.ctl; // R12
            s_d.vec[`TSV_B_UNDR] = s_q.undr_fin; // R13
            s_d.vec[`TSV_B_MCAST] = u_bi.mcast; // R14
            s_d.vec[`TSV_B_BCAST] = u_bi.bcast; // R15
            s_d.vec[`TSV_B_GOOD] = s_q.good_fin; // R16
        end

        // receive flags registered with their own strobe
        s_d.rxvld = rx_flags_valid_i; // R2
        if (rx_flags_valid_i) begin
            s_d.rxvec = '0;
            s_d.rxvec[RX_W-1:0] = rx_flags_i; // R2
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.vlan_en <= `TSV_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers: reads wait one cycle, response always okay
    assign hreadyout_o = !(s_q.dp_act && !s_q.dp_wr && !s_q.rd_done);
    assign hresp_o = 1'b0;
    assign hrdata_o = s_q.rdata;
    assign irq_o = s_q.irq;

    // tx vector: held frame flags with the live byte count overlaid
    always_comb begin
        tx_statistics_vector_o = s_q.vec[TX_W-1:0]; // R1 R4
        tx_statistics_vector_o[`TSV_B_BV_HI:`TSV_B_BV_LO] = s_q.bv; // R5 R6
    end
    assign tx_statistics_valid_o = s_q.vld; // R4 R17
    assign rx_statistics_vector_o = s_q.rxvec[RX_W-1:0]; // R2
    assign rx_statistics_valid_o = s_q.rxvld; // R2
endmodule : tsv_tx_stats
